// ===== common/opf_consts.svh
// constants for the optical frame builder
`ifndef OPF_CONSTS_SVH
`define OPF_CONSTS_SVH
// register byte offsets
`define OPF_CTRL_OFS   4'h0
`define OPF_EXT_OFS    4'h4
`define OPF_DIV_OFS    4'h8
`define OPF_DATA_OFS   4'hC
`define OPF_STAT_OFS   5'h10
// field positions
`define OPF_START_BIT  0
`define OPF_SYNC_BIT   1
`define OPF_BURST_BIT  4
`define OPF_DIM_BIT    14
`define OPF_C200_BIT   15
// reset values
`define OPF_CTRL_RST   32'h0000_0000
`define OPF_EXT_RST    32'h0000_3C00
`define OPF_DIV_RST    16'h0001
// preamble and check figures
`define OPF_FLP_MIN    10'h040
`define OPF_TDP_LEN    4'hF
`define OPF_TDP_REPS   2'h3
`define OPF_TAIL_LEN   10'h006
`define OPF_CRC16_POLY 16'h1021
`define OPF_CRC8_POLY  8'h07
// topology patterns, leftmost bit sent first
`define OPF_PAT_VIS    15'h7964
`define OPF_PAT_PEER   15'h0BBF
`define OPF_PAT_STAR   15'h4609
`define OPF_PAT_BCAST  15'h21A5
`endif

// ===== common/opf_pkg.sv
// types for the optical frame builder
`default_nettype none
package opf_pkg;
    typedef enum logic [3:0] {
        ST_IDLE, ST_FLP, ST_TDP, ST_HDR, ST_HCS, ST_TAIL, ST_EXT, ST_OPTIONAL_FIELD_CHECK, ST_PAY
    } opf_state_t;
    typedef enum logic [1:0] {
        CLS_FIRST, CLS_SECOND, CLS_THIRD, CLS_RSVD
    } opf_class_t;
    typedef struct packed {
        logic       valid;     // bit slot active
        logic       low_rate;  // header rate in force
        logic [2:0] bands;     // per light source bit
    } opf_line_t;
endpackage : opf_pkg
`default_nettype wire

// ===== core/opf_frame_builder.sv
// frame builder: avalon register slave, preamble, header and payload serialiser
`include "opf_consts.svh"
`default_nettype none
module opf_frame_builder #(
    parameter logic [2:0] LOW_BAND_ID = 3'h0,
    parameter int         DIV_W       = 16
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [4:0]       address,
    input  wire logic             read,
    input  wire logic             write,
    input  wire logic [31:0]      writedata,
    output logic      [31:0]      readdata,
    output logic                  waitrequest,
    output opf_pkg::opf_line_t    line
);
    // divider width that the register and the tick compare can serve
    if (DIV_W < 2 || DIV_W > 16) begin : g_div_w_check
        $error("DIV_W out of range");
    end

    // ==========================================================
    // functions
    function automatic opf_pkg::opf_class_t mcs_class(input logic [5:0] m);
        if (m <= 6'h08) mcs_class = opf_pkg::CLS_FIRST;
        else if (m >= 6'h10 && m <= 6'h1D) mcs_class = opf_pkg::CLS_SECOND;
        else if (m >= 6'h20 && m <= 6'h26) mcs_class = opf_pkg::CLS_THIRD;
        else mcs_class = opf_pkg::CLS_RSVD;
    endfunction : mcs_class

    function automatic logic [15:0] crc16(input logic [15:0] c, input logic b);
        crc16 = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? `OPF_CRC16_POLY : 16'h0000);
    endfunction : crc16

    function automatic logic [7:0] crc8(input logic [7:0] c, input logic b);
        crc8 = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? `OPF_CRC8_POLY : 8'h00);
    endfunction : crc8

    // ==========================================================
    // registers and state
    logic [31:0]          ctrl_q;
    logic [31:0]          ext_q;
    logic [DIV_W-1:0]     div_q;
    logic [7:0]           data_q;
    logic                 full_q;
    logic                 start_q;
    logic                 wait_q;
    logic [31:0]          rdata_q;
    opf_pkg::opf_state_t  st_q;
    logic [DIV_W-1:0]     fdiv_q;
    logic [DIV_W-1:0]     dcnt_q;
    logic                 tick;
    logic [9:0]           cnt_q;
    logic [9:0]           flp_len_q;
    logic [1:0]           rep_q;
    logic [31:0]          sh_q;
    logic [15:0]          crc16_q;
    logic [7:0]           crc8_q;
    logic [15:0]          bytes_q;
    logic                 burst_pend_q;
    logic                 sync_q;
    logic                 dim_q;
    logic                 tail_q;
    logic                 three_q;
    logic [14:0]          pat_q;
    logic                 consume;
    opf_pkg::opf_line_t   line_q;
    logic [31:0]          rd_mux;
    logic                 req;
    logic                 take;
    logic                 busy;
    logic [5:0]           mcs_w;
    logic [7:0]           pay_q;
    logic                 pay_bit;

    assign req   = read | write;
    assign take  = req & ~wait_q;
    assign busy  = (st_q != opf_pkg::ST_IDLE) | start_q;
    assign mcs_w = ctrl_q[13:8];

    // ==========================================================
    // avalon read mux
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (address[4:0] == {1'b0, `OPF_CTRL_OFS}) begin
            rd_mux = ctrl_q;
        end else if (address[4:0] == {1'b0, `OPF_EXT_OFS}) begin
            rd_mux = ext_q;
        end else if (address[4:0] == {1'b0, `OPF_DIV_OFS}) begin
            rd_mux = {{(32-DIV_W){1'b0}}, div_q};
        end else if (address[4:0] == `OPF_STAT_OFS) begin
            rd_mux = {27'h0, burst_pend_q, mcs_class(mcs_w), full_q, busy};
        end
    end

    // waitrequest: one wait cycle, data writes wait for free holding byte
    always_ff @(posedge clk) begin
        if (reset) begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else if (!wait_q) begin
            wait_q <= 1'b1;
        end else if (req && !(write && full_q
                     && address == {1'b0, `OPF_DATA_OFS})) begin
            wait_q  <= 1'b0;
            rdata_q <= rd_mux;
        end
    end

    // software registers
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_q  <= `OPF_CTRL_RST;
            ext_q   <= `OPF_EXT_RST;
            div_q   <= DIV_W'(`OPF_DIV_RST);
            start_q <= 1'b0;
        end else begin
            if (take && write && address == {1'b0, `OPF_CTRL_OFS}) begin
                ctrl_q  <= {writedata[31:1], 1'b0};
                start_q <= writedata[`OPF_START_BIT] & ~busy;
            end else if (st_q == opf_pkg::ST_IDLE && tick) begin
                start_q <= 1'b0;
            end
            if (take && write && address == {1'b0, `OPF_EXT_OFS}) begin
                ext_q <= writedata;
            end
            if (take && write && address == {1'b0, `OPF_DIV_OFS}) begin
                div_q <= writedata[DIV_W-1:0];
            end
        end
    end

    // payload holding byte, a new write wins over consumption
    always_ff @(posedge clk) begin
        if (reset) begin
            data_q <= 8'h00;
            full_q <= 1'b0;
        end else if (take && write && address == {1'b0, `OPF_DATA_OFS}) begin
            data_q <= writedata[7:0];
            full_q <= 1'b1;
        end else if (consume) begin
            full_q <= 1'b0;
        end
    end

    // ==========================================================
    // optical clock enable, divider latched per frame
    always_ff @(posedge clk) begin
        if (reset) begin
            dcnt_q <= '0;
            fdiv_q <= DIV_W'(`OPF_DIV_RST);
        end else begin
            if (st_q == opf_pkg::ST_IDLE && !start_q) begin
                fdiv_q <= div_q;
            end
            if (tick) begin
                dcnt_q <= '0;
            end else begin
                dcnt_q <= dcnt_q + 1'b1;
            end
        end
    end
    assign tick = (dcnt_q >= fdiv_q);

    assign consume = tick && st_q == opf_pkg::ST_PAY && cnt_q == 10'h000
                     && full_q && bytes_q != 16'h0000;

    // first payload bit straight from the holding byte, the rest from the copy
    assign pay_bit = (cnt_q == 10'h000) ? data_q[0] : pay_q[cnt_q[2:0]];

    // ==========================================================
    // transmit sequencer, one bit per optical tick
    always_ff @(posedge clk) begin
        if (reset) begin
            st_q         <= opf_pkg::ST_IDLE;
            cnt_q        <= 10'h000;
            flp_len_q    <= `OPF_FLP_MIN;
            rep_q        <= 2'h0;
            sh_q         <= 32'h0;
            crc16_q      <= 16'hFFFF;
            crc8_q       <= 8'hFF;
            bytes_q      <= 16'h0000;
            burst_pend_q <= 1'b0;
            sync_q       <= 1'b0;
            dim_q        <= 1'b0;
            tail_q       <= 1'b0;
            three_q      <= 1'b0;
            pat_q        <= `OPF_PAT_VIS;
            line_q       <= '0;
            pay_q        <= 8'h00;
        end else if (tick) begin
            line_q.valid    <= 1'b1;
            line_q.low_rate <= 1'b0;
            case (st_q)
                opf_pkg::ST_IDLE: begin
                    line_q <= '0;
                    cnt_q  <= 10'h000;
                    rep_q  <= 2'h0;
                    if (start_q) begin
                        sync_q    <= ctrl_q[`OPF_SYNC_BIT];
                        dim_q     <= ctrl_q[`OPF_DIM_BIT];
                        three_q   <= mcs_class(mcs_w) == opf_pkg::CLS_THIRD;
                        tail_q    <= ctrl_q[`OPF_C200_BIT]
                                     && mcs_class(mcs_w) == opf_pkg::CLS_FIRST;
                        bytes_q   <= ctrl_q[31:16];
                        flp_len_q <= `OPF_FLP_MIN + {1'b0, ext_q[31:24], 1'b0};
                        case (ctrl_q[3:2])
                            2'h0: pat_q <= `OPF_PAT_VIS;
                            2'h1: pat_q <= `OPF_PAT_PEER;
                            2'h2: pat_q <= `OPF_PAT_STAR;
                            default: pat_q <= `OPF_PAT_BCAST;
                        endcase
                        // header bits in send order, lowest bit first
                        sh_q <= {5'h00,
                                 ctrl_q[`OPF_DIM_BIT], ctrl_q[31:16], mcs_w,
                                 (mcs_class(mcs_w) == opf_pkg::CLS_THIRD)
                                     ? LOW_BAND_ID : ctrl_q[7:5],
                                 ctrl_q[`OPF_BURST_BIT]};
                        crc16_q <= 16'hFFFF;
                        crc8_q  <= 8'hFF;
                        if (burst_pend_q && !ctrl_q[`OPF_SYNC_BIT]) begin
                            st_q <= opf_pkg::ST_TDP;
                        end else begin
                            st_q <= opf_pkg::ST_FLP;
                        end
                    end
                end
                opf_pkg::ST_FLP: begin
                    // raw alternating bits, one first
                    line_q.bands <= {3{~cnt_q[0]}};
                    if (cnt_q == flp_len_q - 10'h001) begin
                        cnt_q <= 10'h000;
                        st_q  <= sync_q ? opf_pkg::ST_IDLE : opf_pkg::ST_TDP;
                    end else begin
                        cnt_q <= cnt_q + 10'h001;
                    end
                end
                opf_pkg::ST_TDP: begin
                    line_q.bands <= {3{pat_q[4'hE - cnt_q[3:0]] ^ rep_q[0]}};
                    if (cnt_q[3:0] == `OPF_TDP_LEN - 4'h1) begin
                        cnt_q <= 10'h000;
                        rep_q <= rep_q + 2'h1;
                        if (rep_q == `OPF_TDP_REPS) begin
                            st_q <= opf_pkg::ST_HDR;
                        end
                    end else begin
                        cnt_q <= cnt_q + 10'h001;
                    end
                end
                opf_pkg::ST_HDR: begin
                    line_q.low_rate <= 1'b1;
                    line_q.bands    <= three_q ? {3{sh_q[0]}} : {2'b00, sh_q[0]};
                    crc16_q <= crc16(crc16_q, sh_q[0]);
                    sh_q    <= {1'b0, sh_q[31:1]};
                    if (cnt_q == 10'h01F) begin
                        cnt_q <= 10'h000;
                        st_q  <= opf_pkg::ST_HCS;
                    end else begin
                        cnt_q <= cnt_q + 10'h001;
                    end
                end
                opf_pkg::ST_HCS: begin
                    line_q.low_rate <= 1'b1;
                    line_q.bands    <= three_q ? {3{crc16_q[15]}} : {2'b00, crc16_q[15]};
                    crc16_q <= {crc16_q[14:0], 1'b0};
                    sh_q    <= {8'h00, ext_q[23:0]};
                    if (cnt_q == 10'h00F) begin
                        cnt_q <= 10'h000;
                        st_q  <= tail_q ? opf_pkg::ST_TAIL
                               : dim_q ? opf_pkg::ST_EXT : opf_pkg::ST_PAY;
                    end else begin
                        cnt_q <= cnt_q + 10'h001;
                    end
                end
                opf_pkg::ST_TAIL: begin
                    line_q.bands <= 3'b000;
                    if (cnt_q == `OPF_TAIL_LEN - 10'h001) begin
                        cnt_q <= 10'h000;
                        st_q  <= dim_q ? opf_pkg::ST_EXT : opf_pkg::ST_PAY;
                    end else begin
                        cnt_q <= cnt_q + 10'h001;
                    end
                end
                opf_pkg::ST_EXT: begin
                    // compensation, resync, subframe lengths
                    line_q.bands <= {2'b00, sh_q[0]};
                    crc8_q <= crc8(crc8_q, sh_q[0]);
                    sh_q   <= {1'b0, sh_q[31:1]};
                    if (cnt_q == 10'h017) begin
                        cnt_q <= 10'h000;
                        st_q  <= opf_pkg::ST_OPTIONAL_FIELD_CHECK;
                    end else begin
                        cnt_q <= cnt_q + 10'h001;
                    end
                end
                opf_pkg::ST_OPTIONAL_FIELD_CHECK: begin
                    line_q.bands <= {2'b00, crc8_q[7]};
                    crc8_q <= {crc8_q[6:0], 1'b0};
                    if (cnt_q == 10'h007) begin
                        cnt_q <= 10'h000;
                        st_q  <= opf_pkg::ST_PAY;
                    end else begin
                        cnt_q <= cnt_q + 10'h001;
                    end
                end
                opf_pkg::ST_PAY: begin
                    if (bytes_q == 16'h0000 && cnt_q == 10'h000) begin
                        line_q       <= '0;
                        burst_pend_q <= ctrl_q[`OPF_BURST_BIT];
                        st_q         <= opf_pkg::ST_IDLE;
                    end else if (cnt_q == 10'h000 && !full_q) begin
                        line_q.valid <= 1'b0;                                    // stall
                        line_q.bands <= 3'b000;
                    end else begin
                        // payload byte, lowest bit first; the copy keeps a refill
                        // of the holding byte from spoiling the byte on the line
                        line_q.bands <= three_q ? {3{pay_bit}}
                                                : {2'b00, pay_bit};
                        if (cnt_q == 10'h000) begin
                            pay_q <= data_q;
                        end
                        if (cnt_q == 10'h007) begin
                            cnt_q   <= 10'h000;
                            bytes_q <= bytes_q - 16'h0001;
                        end else begin
                            cnt_q <= cnt_q + 10'h001;
                        end
                    end
                end
                default: st_q <= opf_pkg::ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // outputs
    assign readdata    = rdata_q;
    assign waitrequest = wait_q;
    assign line        = line_q;
endmodule : opf_frame_builder
`default_nettype wire

// ===== verif/opf_line_rx.sv
// line receiver model: collects the bits sent on the optical line
`default_nettype none
module opf_line_rx (
    input wire logic               clk,
    input wire logic               reset,
    input wire opf_pkg::opf_line_t line
);
    timeunit 1ns;
    timeprecision 1ns;
    logic bits[$];
    // ==========================================
    // capture
    // one raw on-off keyed bit per active slot, in arrival order
    always @(posedge clk) begin
        if (!reset && line.valid) begin
            bits.push_back(line.bands[0]);
        end
    end
endmodule : opf_line_rx
`default_nettype wire

// ===== verif/opf_frame_builder_assertions.sv
// port checker for the frame builder
`default_nettype none
module opf_fb_checker (
    input wire logic               clk,
    input wire logic               reset,
    input wire logic [4:0]         address,
    input wire logic               read,
    input wire logic               write,
    input wire logic [31:0]        writedata,
    input wire logic [31:0]        readdata,
    input wire logic               waitrequest,
    input wire opf_pkg::opf_line_t line
);
    logic [31:0] hdr_q;
    logic [5:0]  hcnt_q;
    logic        pre_q;
    logic        ctrl_wr;
    logic        start_wr;
    assign ctrl_wr = write && !waitrequest && address == 5'h00;
    assign start_wr = ctrl_wr && writedata[0];
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // ==========================================
    // helper state
    // header word expected from the last control write
    always_ff @(posedge clk) begin
        if (reset) begin
            hdr_q <= 32'h0;
        end else if (ctrl_wr) begin
            hdr_q <= {5'h00, writedata[14], writedata[31:16], writedata[13:8],
                      writedata[7:5], writedata[4]};
        end
    end
    // preamble phase: from start until the first header bit
    always_ff @(posedge clk) begin
        if (reset) begin
            pre_q <= 1'b0;
        end else if (start_wr) begin
            pre_q <= 1'b1;
        end else if (line.low_rate) begin
            pre_q <= 1'b0;
        end
    end
    // index of the header bit now on the line
    always_ff @(posedge clk) begin
        if (reset || start_wr) begin
            hcnt_q <= 6'h0;
        end else if (line.valid && line.low_rate) begin
            hcnt_q <= hcnt_q + 6'h1;
        end
    end
    // ==========================================
    // assertions
    chk_ack_single: assert property (!waitrequest |=> waitrequest)
        else $error("acknowledge held longer than one cycle");
    chk_ack_has_req: assert property (!waitrequest |-> $past(read || write))
        else $error("acknowledge without a request");
    chk_reset_quiet: assert property ($fell(reset) |-> waitrequest && readdata == 32'h0
                                      && line == '0)
        else $error("outputs not at rest after reset");
    chk_ack_bound: assert property ((read || write) && waitrequest && address != 5'h0C
                                    |-> ##[1:2] !waitrequest)
        else $error("register access not answered in time");
    chk_unmapped_zero: assert property (read && !waitrequest
        && !(address inside {5'h00, 5'h04, 5'h08, 5'h0C, 5'h10}) |-> readdata == 32'h0)
        else $error("unmapped read not zero");
    chk_start_reads0: assert property (read && !waitrequest && address == 5'h00
                                       |-> !readdata[0])
        else $error("start bit reads back set");
    chk_pre_bands: assert property (pre_q && line.valid && !line.low_rate
                                    |-> line.bands inside {3'h0, 3'h7})
        else $error("light sources differ during preamble");
    chk_hdr_bits: assert property (line.valid && line.low_rate && hcnt_q < 6'd32
        && !(hcnt_q inside {[6'd1:6'd3]}) |-> line.bands[0] == hdr_q[hcnt_q[4:0]])
        else $error("header bit differs from control word");
    chk_hdr_first: assert property ($rose(line.low_rate) |-> hcnt_q == 6'd0)
        else $error("header does not start at its first bit");
    chk_hdr_bands: assert property (line.valid && line.low_rate
        && hdr_q[9:4] inside {[6'h20:6'h26]} |-> line.bands inside {3'h0, 3'h7})
        else $error("light sources differ during header");
    cover property ($rose(line.low_rate));
    cover property (write && waitrequest && address == 5'h0C ##1 write && waitrequest);
    cover property (read && !waitrequest && address == 5'h14);
endmodule : opf_fb_checker
bind opf_frame_builder opf_fb_checker u_opf_fb_checker (.clk(clk), .reset(reset),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .line(line));
`default_nettype wire

// ===== verif/tb.sv
// testbench: register access and frame bit stream checks
`include "opf_consts.svh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic               clk;
    logic               reset;
    logic               read;
    logic               write;
    logic [4:0]         address;
    logic [31:0]        writedata;
    logic [31:0]        rd;
    wire logic [31:0]   readdata;
    wire logic          waitrequest;
    opf_pkg::opf_line_t line;
    int                 error_cnt;
    int                 comparisons;
    logic               exp_q[$];
    opf_frame_builder u_opf_frame_builder (.clk(clk), .reset(reset), .address(address),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .line(line));
    opf_line_rx u_opf_line_rx (.clk(clk), .reset(reset), .line(line));
    // ==========================================
    // clock and watchdog
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        $display("MISMATCH watchdog exp done got hang");
        conclude();
    end
    // ==========================================
    // shared tasks
    task automatic bus(input logic rw, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        address <= a;
        read <= !rw;
        write <= rw;
        writedata <= d;
        // only the watchdog ends a wait that never gets its answer
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'b0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic chk_bits(input string nm, input int base);
        int bad;
        bad = -1;
        comparisons++;
        for (int i = exp_q.size() - 1; i >= 0; i--)
            if (u_opf_line_rx.bits[base + i] !== exp_q[i]) bad = i;
        if (bad >= 0) begin
            error_cnt++;
            $display("MISMATCH %s bit %0d exp %b got %b", nm, bad, exp_q[bad],
                     u_opf_line_rx.bits[base + bad]);
        end
    endtask : chk_bits
    // expected line bits for a control word, extension word and payload byte
    task automatic build(input logic [31:0] c, input logic [31:0] e, input bit fast_lock_pattern,
                         input logic [7:0] pl);
        logic [15:0] crc;
        logic [7:0]  c8;
        logic [31:0] h;
        logic [14:0] p;
        logic        fb;
        logic [7:0]  b;
        exp_q.delete();
        crc = 16'hFFFF;
        c8 = 8'hFF;
        p = c[3:2] == 2'h0 ? `OPF_PAT_VIS : c[3:2] == 2'h1 ? `OPF_PAT_PEER :
            c[3:2] == 2'h2 ? `OPF_PAT_STAR : `OPF_PAT_BCAST;
        h = {5'h00, c[14], c[31:16], c[13:8], c[7:5], c[4]};
        if (c[13:8] >= 6'h20 && c[13:8] <= 6'h26) h[3:1] = 3'h0;
        for (int i = 0; fast_lock_pattern && i < 64 + 2 * e[31:24]; i++) exp_q.push_back(i % 2 == 0);
        if (c[1]) return;
        for (int i = 0; i < 60; i++) exp_q.push_back(p[14 - i % 15] ^ ((i / 15) % 2 == 1));
        for (int i = 0; i < 32; i++) begin
            exp_q.push_back(h[i]);
            fb = crc[15] ^ h[i];
            crc = {crc[14:0], 1'b0} ^ (fb ? 16'h1021 : 16'h0000);
        end
        for (int i = 15; i >= 0; i--) exp_q.push_back(crc[i]);
        for (int i = 0; c[15] && c[13:8] <= 6'h08 && i < 6; i++) exp_q.push_back(1'b0);
        for (int i = 0; c[14] && i < 24; i++) begin
            exp_q.push_back(e[i]);
            fb = c8[7] ^ e[i];
            c8 = {c8[6:0], 1'b0} ^ (fb ? 8'h07 : 8'h00);
        end
        for (int i = 7; c[14] && i >= 0; i--) exp_q.push_back(c8[i]);
        for (int i = 0; i < 8 * c[31:16]; i++) begin
            b = pl ^ 8'(i / 8);
            exp_q.push_back(b[i % 8]);
        end
    endtask : build
    // one frame: configure, start, feed payload, wait idle, compare stream
    task automatic frame(input string nm, input logic [31:0] c, input logic [31:0] e,
                         input bit fast_lock_pattern, input logic [7:0] pl);
        int base;
        base = u_opf_line_rx.bits.size();
        build(c, e, fast_lock_pattern, pl);
        bus(1'b1, 5'h04, e);
        bus(1'b1, 5'h00, c | 32'h1);
        for (int i = 0; i < c[31:16]; i++) bus(1'b1, 5'h0C, {24'h0, pl ^ 8'(i)});
        do begin
            bus(1'b0, 5'h10, 32'h0);
        end while (rd[0] !== 1'b0);
        repeat (4) @(posedge clk);
        chk({nm, " len"}, 32'(exp_q.size()), 32'(u_opf_line_rx.bits.size() - base));
        chk_bits(nm, base);
        $display("test %s done", nm);
    endtask : frame
    // ==========================================
    // scenarios
    task automatic t_regs();
        bus(1'b0, 5'h04, 32'h0);
        chk("ext reset", 32'h0000_3C00, rd);
        bus(1'b0, 5'h08, 32'h0);
        chk("div reset", 32'h0000_0001, rd);
        bus(1'b0, 5'h00, 32'h0);
        chk("ctrl reset", 32'h0000_0000, rd);
        bus(1'b1, 5'h14, 32'hFFFF_FFFF);
        bus(1'b0, 5'h14, 32'h0);
        chk("unmapped", 32'h0000_0000, rd);
        bus(1'b1, 5'h08, 32'h0);
        $display("test regs done");
    endtask : t_regs
    task automatic t_class();
        logic [5:0] codes[10] = '{6'h00, 6'h08, 6'h09, 6'h10, 6'h1D, 6'h1E, 6'h20, 6'h26,
                                  6'h27, 6'h3F};
        logic [1:0] cls[10] = '{2'h0, 2'h0, 2'h3, 2'h1, 2'h1, 2'h3, 2'h2, 2'h2, 2'h3, 2'h3};
        for (int i = 0; i < 10; i++) begin
            bus(1'b1, 5'h00, {18'h0, codes[i], 8'h00});
            bus(1'b0, 5'h10, 32'h0);
            chk("mcs class", {30'h0, cls[i]}, {30'h0, rd[3:2]});
        end
        $display("test class done");
    endtask : t_class
    task automatic t_burst();
        frame("burst first", 32'h0000_21B0, 32'h0000_3C00, 1'b1, 8'h00);
        bus(1'b0, 5'h10, 32'h0);
        chk("burst pending", 32'h1, {31'h0, rd[4]});
        frame("burst next", 32'h0000_1000, 32'h0000_3C00, 1'b0, 8'h00);
    endtask : t_burst
    // ==========================================
    // main sequence and verdict
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude
    initial begin
        read = 1'b0;
        write = 1'b0;
        address = 5'h0;
        writedata = 32'h0;
        error_cnt = 0;
        comparisons = 0;
        reset = 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        t_regs();
        t_class();
        for (int t = 0; t < 4; t++) begin
            frame("topology", 32'h0400 | (t << 2), 32'h3C00, 1'b1, 8'h0);
        end
        t_burst();
        frame("dimmed", 32'h0002_C008, 32'h00AA_BD55, 1'b1, 8'hA5);
        frame("sync only", 32'h0000_0002, 32'h0200_3C00, 1'b1, 8'h00);
        conclude();
    end
endmodule : tb
`default_nettype wire
